/* File: verilog/port_mux_pkg.sv */
// constants and carrier types for the eight-pin port function multiplexer
package port_mux_pkg;

  // ************************************************
  // bus and register map
  // ************************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N  = 8;

  localparam logic [15:0] OFS_LEVEL = 16'hf220;
  localparam logic [15:0] OFS_DIR   = 16'hf221;
  localparam logic [15:0] OFS_DRV0  = 16'hf222;
  localparam logic [15:0] OFS_DRV1  = 16'hf223;
  localparam logic [15:0] OFS_FSEL0 = 16'hf224;
  localparam logic [15:0] OFS_FSEL1 = 16'hf225;
  localparam logic [7:0]  RST_REG   = 8'h00;

  // ************************************************
  // codes
  // ************************************************
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;

  localparam logic [1:0] DRV_HIZ  = 2'h0;
  localparam logic [1:0] DRV_PCH  = 2'h1;
  localparam logic [1:0] DRV_NCH  = 2'h2;
  localparam logic [1:0] DRV_CMOS = 2'h3;

  localparam logic DIR_OUT = 1'b0;

  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic       dir_in;
    logic [1:0] drv;
    logic       src;
    logic       force_cmos;
    logic       fixed;
    logic       periph_drive;
    logic       periph_oe;
  } pin_req_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pull_up;
    logic pull_down;
  } pad_t;

endpackage : port_mux_pkg

/* File: verilog/pin_sync.sv */
// two flip-flop synchroniser for the pin levels
`timescale 1ns/1ps
module pin_sync
  import port_mux_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : pin_sync

/* File: verilog/pin_drive_cell.sv */
// pad drive decode for one pin
`timescale 1ns/1ps
module pin_drive_cell
  import port_mux_pkg::*;
(
  // request
  input  wire pin_req_t req_i,
  // pad controls
  output pad_t          pad_o
);

  always_comb
  begin
    pad_o = '0;
    if (req_i.periph_drive)
    begin
      pad_o.oe  = req_i.periph_oe;
      pad_o.out = req_i.src;
    end
    else if (req_i.force_cmos)
    begin
      pad_o.oe  = 1'b1;
      pad_o.out = req_i.src;
    end
    else if (req_i.dir_in)
    begin
      pad_o.pull_down = (req_i.drv == DRV_PCH);
      pad_o.pull_up   = (req_i.drv == DRV_NCH);
    end
    else if (req_i.fixed)
    begin
      // prohibited code: N-open and CMOS both hold low
      pad_o.oe = (req_i.drv == DRV_NCH) || (req_i.drv == DRV_CMOS);
    end
    else
    begin
      unique case (req_i.drv)
        DRV_HIZ:
          pad_o.oe = 1'b0;
        DRV_PCH:
        begin
          pad_o.oe  = req_i.src;
          pad_o.out = 1'b1;
        end
        DRV_NCH:
          pad_o.oe = ~req_i.src;
        DRV_CMOS:
        begin
          pad_o.oe  = 1'b1;
          pad_o.out = req_i.src;
        end
      endcase
    end
  end

endmodule : pin_drive_cell

/* File: verilog/port_function_mux.sv */
// eight-pin port with register file and per-pin function multiplexer
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module port_function_mux
  import port_mux_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // board pins
  input  wire logic [PIN_N-1:0]  pin_i,
  output logic      [PIN_N-1:0]  pin_o,
  output logic      [PIN_N-1:0]  pin_oe_o,
  output logic      [PIN_N-1:0]  pin_pull_up_o,
  output logic      [PIN_N-1:0]  pin_pull_down_o,
  // peripheral outputs toward the pins
  input  wire logic              pulse_width_channel_four_i,
  input  wire logic              pulse_width_channel_five_i,
  input  wire logic              sync_serial_zero_out_i,
  input  wire logic              sync_serial_zero_clock_i,
  input  wire logic              sync_serial_zero_clock_oe_i,
  input  wire logic              async_zero_transmit_i,
  input  wire logic              async_one_transmit_i,
  input  wire logic              twi_clock_low_i,
  input  wire logic              twi_data_low_i,
  // pin levels toward the peripherals
  output logic                   sync_serial_zero_in_o,
  output logic                   sync_serial_zero_clock_in_o,
  output logic                   async_zero_receive_o,
  output logic                   twi_clock_in_o,
  output logic                   twi_data_in_o
);

  // ************************************************
  // registers
  // ************************************************
  logic [DATA_W-1:0] level_q, level_d;
  logic [DATA_W-1:0] dir_q, dir_d;
  logic [DATA_W-1:0] drv0_q, drv0_d;
  logic [DATA_W-1:0] drv1_q, drv1_d;
  logic [DATA_W-1:0] fsel0_q, fsel0_d;
  logic [DATA_W-1:0] fsel1_q, fsel1_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [PIN_N-1:0]  pin_s;
  logic [PIN_N-1:0]  level_view;

  pin_sync #(
    .W (PIN_N)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (pin_i),
    .q_o        (pin_s)
  );

  // input-mode bits show the pin, output-mode bits the register
  assign level_view = (dir_q & pin_s) | (~dir_q & level_q);

  always_comb
  begin
    level_d = level_q;
    dir_d   = dir_q;
    drv0_d  = drv0_q;
    drv1_d  = drv1_q;
    fsel0_d = fsel0_q;
    fsel1_d = fsel1_q;
    rdata_d = '0;
    if (wr_i)
    begin
      unique case (addr_i)
        OFS_LEVEL: level_d = wdata_i;
        OFS_DIR:   dir_d   = wdata_i;
        OFS_DRV0:  drv0_d  = wdata_i;
        OFS_DRV1:  drv1_d  = wdata_i;
        OFS_FSEL0: fsel0_d = wdata_i;
        OFS_FSEL1: fsel1_d = wdata_i;
        default:   ;
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        OFS_LEVEL: rdata_d = level_view;
        OFS_DIR:   rdata_d = dir_q;
        OFS_DRV0:  rdata_d = drv0_q;
        OFS_DRV1:  rdata_d = drv1_q;
        OFS_FSEL0: rdata_d = fsel0_q;
        OFS_FSEL1: rdata_d = fsel1_q;
        default:   rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level_q <= RST_REG;
      dir_q   <= RST_REG;
      drv0_q  <= RST_REG;
      drv1_q  <= RST_REG;
      fsel0_q <= RST_REG;
      fsel1_q <= RST_REG;
      rdata_q <= '0;
    end
    else
    begin
      level_q <= level_d;
      dir_q   <= dir_d;
      drv0_q  <= drv0_d;
      drv1_q  <= drv1_d;
      fsel0_q <= fsel0_d;
      fsel1_q <= fsel1_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ************************************************
  // function multiplexer
  // ************************************************
  logic [1:0] code [PIN_N];
  pin_req_t   req  [PIN_N];

  always_comb
  begin
    for (int i = 0; i < PIN_N; i++)
    begin
      code[i]              = {fsel1_q[i], fsel0_q[i]};
      req[i]               = '0;
      req[i].dir_in        = dir_q[i];
      req[i].drv           = {drv1_q[i], drv0_q[i]};
      req[i].src           = level_q[i];
    end
    unique case (code[7])
      FN_GPIO: ;
      FN_ALT2: req[7].src = pulse_width_channel_five_i;
      FN_ALT1, FN_ALT3: req[7].fixed = 1'b1;
    endcase
    unique case (code[6])
      FN_GPIO: ;
      FN_ALT2:
      begin
        req[6].src        = sync_serial_zero_out_i;
        req[6].force_cmos = 1'b1;
      end
      FN_ALT1, FN_ALT3: req[6].fixed = 1'b1;
    endcase
    unique case (code[5])
      FN_GPIO: ;
      FN_ALT2:
      begin
        req[5].src        = sync_serial_zero_clock_i;
        req[5].force_cmos = 1'b1;
      end
      FN_ALT1, FN_ALT3: req[5].fixed = 1'b1;
    endcase
    unique case (code[4])
      FN_GPIO, FN_ALT2: ;
      FN_ALT1, FN_ALT3: req[4].fixed = 1'b1;
    endcase
    unique case (code[3])
      FN_GPIO: ;
      FN_ALT1:
      begin
        req[3].src        = async_zero_transmit_i;
        req[3].force_cmos = 1'b1;
      end
      FN_ALT2: req[3].src = pulse_width_channel_four_i;
      FN_ALT3:
      begin
        req[3].src        = async_one_transmit_i;
        req[3].force_cmos = 1'b1;
      end
    endcase
    unique case (code[2])
      FN_GPIO, FN_ALT1: ;
      FN_ALT2:
      begin
        req[2].src        = sync_serial_zero_out_i;
        req[2].force_cmos = 1'b1;
      end
      FN_ALT3: req[2].fixed = 1'b1;
    endcase
    unique case (code[1])
      FN_GPIO: ;
      FN_ALT1:
      begin
        // open-drain two-wire clock: only ever pulls low
        req[1].src          = 1'b0;
        req[1].periph_drive = 1'b1;
        req[1].periph_oe    = twi_clock_low_i;
      end
      FN_ALT2:
      begin
        req[1].src          = sync_serial_zero_clock_i;
        req[1].periph_drive = 1'b1;
        req[1].periph_oe    = sync_serial_zero_clock_oe_i;
      end
      FN_ALT3: req[1].fixed = 1'b1;
    endcase
    unique case (code[0])
      FN_GPIO, FN_ALT2: ;
      FN_ALT1:
      begin
        req[0].src          = 1'b0;
        req[0].periph_drive = 1'b1;
        req[0].periph_oe    = twi_data_low_i;
      end
      FN_ALT3: req[0].fixed = 1'b1;
    endcase
  end

  // ************************************************
  // pad drive, registered per pin
  // ************************************************
  pad_t pad_d [PIN_N];
  pad_t pad_q [PIN_N];

  for (genvar g = 0; g < PIN_N; g++)
  begin : g_pin
    pin_drive_cell u_cell (
      .req_i (req[g]),
      .pad_o (pad_d[g])
    );

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
      if (rst_i)
        pad_q[g] <= '0;
      else
        pad_q[g] <= pad_d[g];
    end

    assign pin_o[g]           = pad_q[g].out;
    assign pin_oe_o[g]        = pad_q[g].oe;
    assign pin_pull_up_o[g]   = pad_q[g].pull_up;
    assign pin_pull_down_o[g] = pad_q[g].pull_down;

    nch_drive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      code[g] == FN_GPIO && dir_q[g] == DIR_OUT && req[g].drv == DRV_NCH
      |=> pin_oe_o[g] == !$past(level_q[g]) && !pin_o[g])
      else $error("n-channel open drain does not follow data");
  end

  // ************************************************
  // routing toward the peripherals
  // ************************************************
  logic [4:0] route_q, route_d;

  always_comb
  begin
    route_d    = 5'h00;
    // idle levels: sync serial data and clock in low, async receive and two-wire clock and data high
    route_d[0] = (code[4] == FN_ALT2) ? pin_s[4] :
                 (code[0] == FN_ALT2) ? pin_s[0] : 1'b0;
    route_d[1] = (code[1] == FN_ALT2) ? pin_s[1] : 1'b0;
    route_d[2] = (code[2] == FN_ALT1) ? pin_s[2] : 1'b1;
    route_d[3] = (code[1] == FN_ALT1) ? pin_s[1] : 1'b1;
    route_d[4] = (code[0] == FN_ALT1) ? pin_s[0] : 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      route_q <= 5'h1c;
    else
      route_q <= route_d;
  end

  assign sync_serial_zero_in_o       = route_q[0];
  assign sync_serial_zero_clock_in_o = route_q[1];
  assign async_zero_receive_o        = route_q[2];
  assign twi_clock_in_o              = route_q[3];
  assign twi_data_in_o               = route_q[4];

  // ************************************************
  // checks
  // ************************************************
  fsel_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_i && addr_i == OFS_FSEL0 |=> fsel0_q == $past(wdata_i))
    else $error("function select low not written");

  level_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rd_i && addr_i == OFS_LEVEL
    |=> rdata_o == (($past(dir_q) & $past(pin_s)) | (~$past(dir_q) & $past(level_q))))
    else $error("data read does not mix pin and register");

  read_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data outside its cycle");

  pwm_five_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    code[7] == FN_ALT2 && !dir_q[7] && req[7].drv == DRV_CMOS
    |=> pin_oe_o[7] && pin_o[7] == $past(pulse_width_channel_five_i))
    else $error("pwm five not on pin 7");

  prohib_fixed_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    req[7].fixed && !dir_q[7]
    |=> !pin_o[7] && pin_oe_o[7] == ($past(drv1_q[7])))
    else $error("prohibited pin not fixed");

  serial_cmos_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    code[6] == FN_ALT2 ##0 (req[6].drv == DRV_HIZ || dir_q[6])
    |=> pin_oe_o[6] && pin_o[6] == $past(sync_serial_zero_out_i))
    else $error("serial output not forced to push-pull");

  uart_one_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    code[3] == FN_ALT3 |=> pin_oe_o[3] && pin_o[3] == $past(async_one_transmit_i))
    else $error("uart one transmit not on pin 3");

  twi_clock_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    code[1] == FN_ALT1 |=> pin_oe_o[1] == $past(twi_clock_low_i) && !pin_o[1])
    else $error("two-wire clock not open drain");

  pull_up_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    code[4] == FN_GPIO && dir_q[4] && req[4].drv == DRV_NCH
    |=> pin_pull_up_o[4] && !pin_oe_o[4] && !pin_pull_down_o[4])
    else $error("input pull-up missing");

  rx_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    code[2] == FN_ALT1 |=> async_zero_receive_o == $past(pin_s[2]))
    else $error("receive input not routed from pin 2");

  reset_hiz_a: assert property (@(posedge core_clk_i)
    $past(rst_i) |-> pin_oe_o == '0 && pin_pull_up_o == '0 && pin_pull_down_o == '0)
    else $error("pins not high impedance after reset");

endmodule : port_function_mux

/* File: verification/board_model.sv */
// board circuitry model resolving the port pin levels
`timescale 1ns/1ps
module board_model
(
  // clock
  input  wire logic       core_clk_i,
  // pad controls from the port
  input  wire logic [7:0] pad_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] pd_i,
  // external drivers on the board
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_lvl_i,
  // resolved pin levels
  output logic      [7:0] lvl_o
);
  // ***********
  // resolution
  // ***********
  logic [7:0] float_q = 8'h00;

  // an undriven pin shows a pattern that changes every cycle
  always_ff @(posedge core_clk_i)
    float_q <= ~float_q;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (oe_i[i])
        lvl_o[i] = pad_i[i];
      else if (ext_en_i[i])
        lvl_o[i] = ext_lvl_i[i];
      else if (pu_i[i])
        lvl_o[i] = 1'b1;
      else if (pd_i[i])
        lvl_o[i] = 1'b0;
      else
        lvl_o[i] = float_q[i];
    end
  end
endmodule : board_model

/* File: verification/eight_bit_port_function_mux_test.sv */
// self-checking bench for the port function multiplexer
`timescale 1ns/1ps
module eight_bit_port_function_mux_test;
  import port_mux_pkg::*;
  // ***********
  // signals
  // ***********
  typedef struct {logic [7:0] dir, c0, c1, dat, oe, out, pu, pd;} row_t;
  logic       core_clk_i = 1'b0;
  logic       rst_i      = 1'b1;
  logic [15:0] addr_i    = 16'h0000;
  logic [7:0] wdata_i    = 8'h00;
  logic       wr_i       = 1'b0;
  logic       rd_i       = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] lvl, pin_o, pin_oe_o, pu, pd;
  logic [7:0] ext_en     = 8'h00;
  logic [7:0] ext_lvl    = 8'h00;
  logic [8:0] per        = 9'h000;
  logic       sin, sck_in, rx0, scl_in, sda_in;
  int         miscompares = 0;
  int         n_checks    = 0;
  row_t rows [8] = '{
    '{8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h00, 8'hff, 8'hff, 8'h55, 8'hff, 8'h55, 8'h00, 8'h00},
    '{8'h00, 8'hff, 8'h00, 8'h55, 8'h55, 8'h55, 8'h00, 8'h00},
    '{8'h00, 8'h00, 8'hff, 8'h55, 8'haa, 8'h00, 8'h00, 8'h00},
    '{8'hff, 8'hff, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'hff},
    '{8'hff, 8'h00, 8'hff, 8'h55, 8'h00, 8'h00, 8'hff, 8'h00},
    '{8'hff, 8'hff, 8'hff, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h0f, 8'h00, 8'hff, 8'h33, 8'hc0, 8'h00, 8'h0f, 8'h00}};

  always #12.5 core_clk_i = ~core_clk_i;

  port_function_mux port_function_mux_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(lvl), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_pull_up_o(pu), .pin_pull_down_o(pd),
    .pulse_width_channel_four_i(per[0]), .pulse_width_channel_five_i(per[1]),
    .sync_serial_zero_out_i(per[2]), .sync_serial_zero_clock_i(per[3]),
    .sync_serial_zero_clock_oe_i(per[4]), .async_zero_transmit_i(per[5]),
    .async_one_transmit_i(per[6]), .twi_clock_low_i(per[7]), .twi_data_low_i(per[8]),
    .sync_serial_zero_in_o(sin), .sync_serial_zero_clock_in_o(sck_in),
    .async_zero_receive_o(rx0), .twi_clock_in_o(scl_in), .twi_data_in_o(sda_in));

  board_model board_model_i (
    .core_clk_i(core_clk_i), .pad_i(pin_o), .oe_i(pin_oe_o), .pu_i(pu), .pd_i(pd),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .lvl_o(lvl));

  // ***********
  // tasks
  // ***********
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask : rdc

  task automatic cfg(input logic [7:0] dir, c0, c1, dat);
    wr(OFS_DIR, dir);
    wr(OFS_DRV0, c0);
    wr(OFS_DRV1, c1);
    wr(OFS_LEVEL, dat);
  endtask : cfg

  task automatic padc(input logic [7:0] oe, out, u, d);
    repeat (4) @(posedge core_clk_i);
    #1 chk("pin_oe", oe, pin_oe_o);
    chk("pin_out", out, pin_o & oe);
    chk("pull_up", u, pu);
    chk("pull_down", d, pd);
  endtask : padc

  task automatic ins(input logic s, c, r, l, t);
    chk("routed", {3'h0, s, c, r, l, t}, {3'h0, sin, sck_in, rx0, scl_in, sda_in});
  endtask : ins

  // ***********
  // sequence
  // ***********
  initial
  begin
    #100us;
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    padc(8'h00, 8'h00, 8'h00, 8'h00);
    ins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    for (int a = 0; a < 6; a++)
      rdc(OFS_LEVEL + a[15:0], RST_REG);
    foreach (rows[i])
    begin
      cfg(rows[i].dir, rows[i].c0, rows[i].c1, rows[i].dat);
      padc(rows[i].oe, rows[i].out, rows[i].pu, rows[i].pd);
    end
    rdc(OFS_DIR, 8'h0f);
    rdc(OFS_LEVEL, 8'h3f);
    wr(16'hf226, 8'hff);
    rdc(16'hf226, 8'h00);
    @(posedge core_clk_i);
    ext_en  <= 8'hff;
    ext_lvl <= 8'ha5;
    cfg(8'hff, 8'h00, 8'h00, 8'h00);
    repeat (3) @(posedge core_clk_i);
    rdc(OFS_LEVEL, 8'ha5);
    @(posedge core_clk_i);
    ext_en  <= 8'h12;
    ext_lvl <= 8'h10;
    per     <= 9'h12e;
    cfg(8'h10, 8'hff, 8'hff, 8'h00);
    wr(OFS_FSEL0, 8'h0b);
    wr(OFS_FSEL1, 8'hf4);
    padc(8'hed, 8'hec, 8'h00, 8'h00);
    ins(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge core_clk_i);
    ext_en  <= 8'h05;
    ext_lvl <= 8'h01;
    per     <= 9'h058;
    cfg(8'h05, 8'h00, 8'hff, 8'hff);
    wr(OFS_FSEL0, 8'hfc);
    wr(OFS_FSEL1, 8'h5b);
    padc(8'hfa, 8'h0a, 8'h05, 8'h00);
    ins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    @(posedge core_clk_i);
    per <= 9'h001;
    cfg(8'h00, 8'hff, 8'hff, 8'h00);
    wr(OFS_FSEL0, 8'h00);
    wr(OFS_FSEL1, 8'h08);
    padc(8'hff, 8'h08, 8'h00, 8'h00);
    // prohibited codes under every drive, serial output forced over hiz drive
    @(posedge core_clk_i);
    per <= 9'h044;
    cfg(8'h00, 8'ha6, 8'h94, 8'hff);
    wr(OFS_FSEL0, 8'hbf);
    wr(OFS_FSEL1, 8'hff);
    padc(8'hdc, 8'h48, 8'h00, 8'h00);
    ins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    // analog use: upper pins parked as hiz outputs, data ignored
    cfg(8'h00, 8'h00, 8'h00, 8'hf0);
    wr(OFS_FSEL0, 8'h00);
    wr(OFS_FSEL1, 8'h00);
    padc(8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    padc(8'h00, 8'h00, 8'h00, 8'h00);
    rdc(OFS_FSEL1, RST_REG);
    close_out();
  end
endmodule : eight_bit_port_function_mux_test
